/* File: hdl/ext_mem_bus_timing.sv */
// external data memory timing generator on a multiplexed address/data bus
// assumes an sfr bus on sys_clk and a cpu request held until done pulses
`timescale 1ns/1ps
`include "ext_mem_defs.svh"
// What this block does
// - bits 7:6 of the timing register add 0 to 3 cycles of address setup before the strobe.
// - bits 5:2 set read and write strobe width to the field plus one cycles.
// - bits 1:0 keep address and control valid 0 to 3 cycles after the strobe.
// - the timing register sits at sfr address 0xAA on sfr page 0x0F.
// - the latch strobe is held high, then low, for 1 to 4 cycles each.
// - write data is on the bus 1 to 19 cycles before the write strobe ends.
// - write data stays driven 0 to 3 cycles after the write strobe, per the hold setting.
// - the multiplexed sequence applies for 8-bit and 16-bit moves in modes 001, 010 and 011.
// - 8-bit moves in modes 001 and 011 leave the upper address byte undriven.
// - after reset setup and hold take their maximum values.
// - a two-bit latch field sets latch high and low widths to its value plus one.
// - each access lasts four cycles plus setup, strobe, hold and latch cycles.
// - the low address byte is on the bus while the latch strobe is high and then low, data after.
module ext_mem_bus_timing
   import ext_mem_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // sfr access
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_page,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   output logic sfr_hit,
   // configuration
   input wire logic [2:0] mode_sel,
   input wire logic [1:0] ale_width_sel,
   // cpu move request
   input wire logic req,
   input wire logic req_write,
   input wire logic req_ptr16,
   input wire logic [15:0] req_addr,
   input wire logic [7:0] req_wdata,
   output logic busy,
   output logic done,
   output logic [7:0] rd_data,
   // external pins
   output logic ale,
   output logic rd_n,
   output logic wr_n,
   output logic [7:0] ad_out,
   output logic ad_oe,
   input wire logic [7:0] ad_in,
   output logic [7:0] addr_hi,
   output logic addr_hi_oe
);
   phase_if ph ();
   phase_t state_reg, state_next;
   logic [7:0] tc_reg;
   logic [7:0] ad_sync1_reg, ad_sync2_reg;
   logic [15:0] addr_reg;
   logic [7:0] wdata_reg;
   logic write_reg, hi_drive_reg;
   logic cap1_reg, cap2_reg;

   // one timer serves every phase, so two phases can never overlap
   phase_timer u_timer (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .ph(ph)
   );

   wire tc_sel = (sfr_addr == `TC_SFR_ADDR) && (sfr_page == `TC_SFR_PAGE);
   wire [1:0] setup_f = tc_reg[`TC_SETUP_HI:`TC_SETUP_LO];
   wire [3:0] width_f = tc_reg[`TC_WIDTH_HI:`TC_WIDTH_LO];
   wire [1:0] hold_f = tc_reg[`TC_HOLD_HI:`TC_HOLD_LO];
   wire mux_mode = (mode_sel == 3'h1) || (mode_sel == 3'h2) || (mode_sel == 3'h3);
   // in modes 001/011 an 8-bit move leaves the upper byte to the port latches
   wire hi_drive_next = req_ptr16 || (mode_sel == 3'h2);
   wire start = (state_reg == PH_IDLE) && req && mux_mode;
   wire in_strobe = (state_reg == PH_STROBE);

   assign sfr_hit = tc_sel;
   assign sfr_rdata = tc_sel ? tc_reg : 8'h00;
   assign busy = (state_reg != PH_IDLE);
   // done marks the last tail cycle; the cpu drops req there to avoid a restart
   assign done = (state_reg == PH_TAIL) && ph.done;

   // next state and the count loaded for it; each phase lasts count+1 cycles
   always_comb begin
      state_next = state_reg;
      ph.load = 1'b0;
      ph.count = 4'h0;
      case (state_reg)
         PH_IDLE: if (start) begin
            state_next = PH_ALE_HI;
            ph.load = 1'b1;
            ph.count = {2'b00, ale_width_sel};
         end
         PH_ALE_HI: if (ph.done) begin
            state_next = PH_ALE_LO;
            ph.load = 1'b1;
            ph.count = {2'b00, ale_width_sel};
         end
         PH_ALE_LO: if (ph.done) begin
            state_next = (setup_f == 2'h0) ? PH_STROBE : PH_SETUP;
            ph.load = 1'b1;
            ph.count = (setup_f == 2'h0) ? width_f : {2'b00, setup_f - 2'h1};
         end
         PH_SETUP: if (ph.done) begin
            state_next = PH_STROBE;
            ph.load = 1'b1;
            ph.count = width_f;
         end
         PH_STROBE: if (ph.done) begin
            state_next = (hold_f == 2'h0) ? PH_TAIL : PH_HOLD;
            ph.load = 1'b1;
            // the fixed overhead cycles close the access in the tail phase
            ph.count = (hold_f == 2'h0) ? 4'(`EXTERNAL_DATA_MOVE_BASE_CYCLES - 1)
                                        : {2'b00, hold_f - 2'h1};
         end
         PH_HOLD: if (ph.done) begin
            state_next = PH_TAIL;
            ph.load = 1'b1;
            ph.count = 4'(`EXTERNAL_DATA_MOVE_BASE_CYCLES - 1);
         end
         PH_TAIL: if (ph.done) begin
            state_next = PH_IDLE;
         end
         default: state_next = PH_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= PH_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // a write during an access changes the phases of that access still to come
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tc_reg <= `TC_RESET;
      end else if (sfr_wr && tc_sel) begin
         tc_reg <= sfr_wdata;
      end
   end

   // the request is latched once so the cpu may change its fields mid-access
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_reg <= 16'h0000;
         wdata_reg <= 8'h00;
         write_reg <= 1'b0;
         hi_drive_reg <= 1'b0;
      end else if (start) begin
         addr_reg <= req_addr;
         wdata_reg <= req_wdata;
         write_reg <= req_write;
         hi_drive_reg <= hi_drive_next;
      end
   end

   // bus pins are asynchronous to sys_clk, so two stages precede the capture
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ad_sync1_reg <= 8'h00;
         ad_sync2_reg <= 8'h00;
      end else begin
         ad_sync1_reg <= ad_in;
         ad_sync2_reg <= ad_sync1_reg;
      end
   end

   // the bus byte sampled on the edge that ends the strobe leaves the second
   // stage two edges later, so the capture flag is delayed to match
   wire cap_now = in_strobe && ph.done && !write_reg;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cap1_reg <= 1'b0;
         cap2_reg <= 1'b0;
         rd_data <= 8'h00;
      end else begin
         cap1_reg <= cap_now;
         cap2_reg <= cap1_reg;
         if (cap2_reg) begin
            rd_data <= ad_sync2_reg;
         end
      end
   end

   // pins are decoded from the next state so they change on the edge that
   // enters each phase; at the start edge the request itself gives the address
   wire [15:0] addr_cur = start ? req_addr : addr_reg;
   wire hi_drive_cur = start ? hi_drive_next : hi_drive_reg;
   wire addr_phase = (state_next == PH_ALE_HI) || (state_next == PH_ALE_LO);
   wire data_phase = (state_next == PH_SETUP) || (state_next == PH_STROBE)
                     || (state_next == PH_HOLD);
   wire [7:0] ad_next = addr_phase ? addr_cur[7:0] : (data_phase ? wdata_reg : 8'h00);
   wire ad_oe_next = addr_phase || (data_phase && write_reg);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ale <= 1'b0;
         rd_n <= 1'b1;
         wr_n <= 1'b1;
         ad_out <= 8'h00;
         ad_oe <= 1'b0;
         addr_hi <= 8'h00;
         addr_hi_oe <= 1'b0;
      end else begin
         ale <= (state_next == PH_ALE_HI);
         rd_n <= !((state_next == PH_STROBE) && !write_reg && state_reg != PH_IDLE);
         wr_n <= !((state_next == PH_STROBE) && write_reg && state_reg != PH_IDLE);
         ad_out <= ad_next;
         ad_oe <= ad_oe_next;
         addr_hi <= addr_cur[15:8];
         addr_hi_oe <= hi_drive_cur && (addr_phase || data_phase);
      end
   end
endmodule

/* File: hdl/ext_mem_defs.svh */
// constants for the external memory timing block: register address, fields, resets
// assumes inclusion by bare name from the design files
`ifndef EXT_MEM_DEFS_SVH
`define EXT_MEM_DEFS_SVH
`define TC_SFR_ADDR 8'hAA
`define TC_SFR_PAGE 8'h0F
`define TC_SETUP_HI 7
`define TC_SETUP_LO 6
`define TC_WIDTH_HI 5
`define TC_WIDTH_LO 2
`define TC_HOLD_HI 1
`define TC_HOLD_LO 0
`define TC_RESET 8'hFF
`define EXTERNAL_DATA_MOVE_BASE_CYCLES 4
`endif

/* File: hdl/ext_mem_pkg.sv */
// types shared by the external memory timing block
// no assumptions beyond a SystemVerilog compiler
package ext_mem_pkg;
   typedef enum logic [2:0] {
      PH_IDLE, PH_ALE_HI, PH_ALE_LO, PH_SETUP, PH_STROBE, PH_HOLD, PH_TAIL
   } phase_t;
endpackage

/* File: hdl/phase_if.sv */
// carries the phase counter load and expiry between timer and sequencer
// assumes both ends share sys_clk
`timescale 1ns/1ps
interface phase_if;
   logic load;
   logic [3:0] count;
   logic done;
   modport seq (output load, output count, input done);
   modport tmr (input load, input count, output done);
endinterface

/* File: hdl/phase_timer.sv */
// down counter timing one phase of an external access
// assumes load is a one-cycle pulse from the sequencer on the same clock
`timescale 1ns/1ps
module phase_timer (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // sequencer side
   phase_if.tmr ph
);
   logic [3:0] cnt_reg;
   logic busy_reg;
   // done pulses when the loaded count of cycles has elapsed
   assign ph.done = busy_reg && (cnt_reg == 4'h0);
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 4'h0;
         busy_reg <= 1'b0;
      end else if (ph.load) begin
         cnt_reg <= ph.count;
         busy_reg <= 1'b1;
      end else if (ph.done) begin
         busy_reg <= 1'b0;
      end else if (busy_reg) begin
         cnt_reg <= cnt_reg - 4'h1;
      end
   end
endmodule

/* File: test/ext_mem_checker.sv */
// pin assertions for the external memory timing block
// assumes a bind into the design top; mirrors the timing register from sfr writes
`timescale 1ns/1ps
`include "ext_mem_defs.svh"
module ext_mem_checker (
   // clock and reset
   input wire logic sys_clk, rst_n,
   // sfr and request side
   input wire logic [7:0] sfr_addr, sfr_page, sfr_wdata, req_wdata,
   input wire logic sfr_wr, sfr_hit, req_ptr16, done,
   input wire logic [2:0] mode_sel,
   input wire logic [1:0] ale_width_sel,
   input wire logic [15:0] req_addr,
   // pins
   input wire logic ale, rd_n, wr_n, ad_oe, addr_hi_oe,
   input wire logic [7:0] ad_out, addr_hi
);
   logic [7:0] treg;
   logic [4:0] scnt;
   logic [2:0] acnt;
   wire sel = sfr_addr == `TC_SFR_ADDR && sfr_page == `TC_SFR_PAGE;
   wire s_low = !rd_n || !wr_n;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         treg <= `TC_RESET;
         scnt <= 5'h0;
         acnt <= 3'h0;
      end else begin
         if (sfr_wr && sel) treg <= sfr_wdata;
         scnt <= s_low ? scnt + 5'h1 : 5'h0;
         acnt <= ale ? acnt + 3'h1 : 3'h0;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_sel; sfr_hit == sel; endproperty
   a_sel: assert property (p_sel) else $error("select decode wrong");
   property p_excl; !(!rd_n && !wr_n); endproperty
   a_excl: assert property (p_excl) else $error("both strobes low");
   property p_width; (!s_low && scnt != 5'h0) |-> scnt == {1'b0, treg[5:2]} + 5'h1; endproperty
   a_width: assert property (p_width) else $error("strobe width wrong");
   property p_ale; (!ale && acnt != 3'h0) |-> acnt == {1'b0, ale_width_sel} + 3'h1; endproperty
   a_ale: assert property (p_ale) else $error("latch pulse width wrong");
   property p_lo; ale |-> ad_oe && ad_out == req_addr[7:0]; endproperty
   a_lo: assert property (p_lo) else $error("low address missing");
   property p_wdat; !wr_n |-> ad_oe && ad_out == req_wdata; endproperty
   a_wdat: assert property (p_wdat) else $error("write data missing");
   property p_whold; ($rose(wr_n) && treg[1:0] != 2'h0) |-> ad_oe && ad_out == req_wdata;
   endproperty
   a_whold: assert property (p_whold) else $error("write data hold short");
   property p_hi16; (s_low && req_ptr16) |-> addr_hi_oe && addr_hi == req_addr[15:8]; endproperty
   a_hi16: assert property (p_hi16) else $error("upper address wrong");
   property p_hi8; (s_low && !req_ptr16 && mode_sel != 3'h2) |-> !addr_hi_oe; endproperty
   a_hi8: assert property (p_hi8) else $error("upper address driven");
   property p_hibank; (s_low && mode_sel == 3'h2) |-> addr_hi_oe && addr_hi == req_addr[15:8];
   endproperty
   a_hibank: assert property (p_hibank) else $error("bank byte missing");
   property p_done; done |-> rd_n && wr_n && !ale; endproperty
   a_done: assert property (p_done) else $error("done before strobes end");
endmodule
bind ext_mem_bus_timing ext_mem_checker chk_u (
   .sys_clk(sys_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_page(sfr_page),
   .sfr_wdata(sfr_wdata), .req_wdata(req_wdata), .sfr_wr(sfr_wr), .sfr_hit(sfr_hit),
   .req_ptr16(req_ptr16), .done(done), .mode_sel(mode_sel), .ale_width_sel(ale_width_sel),
   .req_addr(req_addr), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .ad_oe(ad_oe),
   .addr_hi_oe(addr_hi_oe), .ad_out(ad_out), .addr_hi(addr_hi)
);

/* File: test/sram_model.sv */
// address latch plus sram on the multiplexed bus
// assumes nothing else drives the bus; an undriven upper byte reads as zero
`timescale 1ns/1ps
module sram_model (
   // pins from the design
   input wire logic ale, rd_n, wr_n, ad_oe, addr_hi_oe,
   input wire logic [7:0] ad_out, addr_hi,
   // bus level seen by the design
   output logic [7:0] ad_in
);
   logic [7:0] mem [65536];
   logic [7:0] lat_lo = 8'h00;
   logic [7:0] idle_v = 8'h00;
   wire [15:0] a = {addr_hi_oe ? addr_hi : 8'h00, lat_lo};
   // the latch takes the bus byte at the fall of ale and holds it from then
   always @(negedge ale) lat_lo = ad_out;
   always @(negedge wr_n) #1 mem[a] = ad_out;
   // a released bus floats, so show the inverse of the last byte
   always @(posedge rd_n) idle_v = ~mem[a];
   assign ad_in = ad_oe ? ad_out : (rd_n === 1'b0) ? mem[a] : idle_v;
endmodule

/* File: test/tb_top.sv */
// self-checking bench for the external memory timing block
// assumes the sram model on the bus and the checker bound to the design
`timescale 1ns/1ps
module tb_top;
   logic sys_clk = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, req = 1'b0, req_write, req_ptr16;
   logic [7:0] sfr_addr = 8'h00, sfr_page = 8'h00, sfr_wdata = 8'h00, req_wdata = 8'h00;
   logic [7:0] sfr_rdata, rd_data, ad_in, ad_out, addr_hi;
   logic [2:0] mode_sel = 3'h1;
   logic [1:0] ale_width_sel = 2'h3;
   logic [15:0] req_addr = 16'h0000;
   logic sfr_hit, busy, done, ale, rd_n, wr_n, ad_oe, addr_hi_oe;
   logic [7:0] tcs [4] = '{8'hFF, 8'h08, 8'hB5, 8'h4E};
   logic [1:0] als [4] = '{2'h3, 2'h0, 2'h1, 2'h2};
   int n_fail = 0, checked = 0, cyc = 0;
   ext_mem_bus_timing dut_u (
      .sys_clk(sys_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_page(sfr_page),
      .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
      .mode_sel(mode_sel), .ale_width_sel(ale_width_sel), .req(req), .req_write(req_write),
      .req_ptr16(req_ptr16), .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy),
      .done(done), .rd_data(rd_data), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .ad_out(ad_out),
      .ad_oe(ad_oe), .ad_in(ad_in), .addr_hi(addr_hi), .addr_hi_oe(addr_hi_oe)
   );
   sram_model mem_u (
      .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .ad_oe(ad_oe), .addr_hi_oe(addr_hi_oe),
      .ad_out(ad_out), .addr_hi(addr_hi), .ad_in(ad_in)
   );
   always #5 sys_clk = ~sys_clk;
   task automatic tick(); @(posedge sys_clk); #1; endtask
   task automatic print_verdict();
      $display("counts: checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         print_verdict();
      end
   end
   task automatic chk(input logic [7:0] got, exp, input string what);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic sfr_w(input logic [7:0] ad, pg, d);
      sfr_addr = ad; sfr_page = pg; sfr_wdata = d; sfr_wr = 1'b1; tick(); sfr_wr = 1'b0;
   endtask
   task automatic sfr_r(input logic [7:0] ad, pg, exp);
      sfr_addr = ad; sfr_page = pg; tick(); chk(sfr_rdata, exp, "sfr read");
   endtask
   // a refused move never sees done, so its length reads as the wait bound
   task automatic move(input logic w, p, input logic [15:0] a, input logic [7:0] d, n_exp);
      int n;
      n = 0; req = 1'b1; req_write = w; req_ptr16 = p; req_addr = a; req_wdata = d;
      do begin tick(); n++; end while (done !== 1'b1 && n < 60);
      chk({7'h00, busy}, {7'h00, n_exp != 8'h3C}, "busy");
      req = 1'b0;
      chk(n[7:0], n_exp, "move length");
      tick();
   endtask
   function automatic logic [7:0] len(input logic [7:0] tc, input logic [1:0] al);
      return 8'h07 + {5'h00, al, 1'b0} + tc[7:6] + tc[5:2] + tc[1:0];
   endfunction
   initial begin
      repeat (6) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      tick();
      sfr_r(8'hAA, 8'h0F, 8'hFF);
      sfr_r(8'hAA, 8'h0E, 8'h00);
      chk({7'h00, sfr_hit}, 8'h00, "select");
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         if (i > 0) sfr_w(8'hAA, 8'h0F, tcs[i]);
         ale_width_sel = als[i];
         mode_sel = 3'(i % 3 + 1);
         sfr_r(8'hAA, 8'h0F, tcs[i]);
         for (int p = 1; p >= 0; p--) begin
            move(1'b1, p[0], {7'h00, p[0], 8'h40} + 16'(i), 8'(8'h3C + 16 * p + i),
               len(tcs[i], als[i]));
            move(1'b0, p[0], {7'h00, p[0], 8'h40} + 16'(i), 8'h00, len(tcs[i], als[i]));
            chk(rd_data, 8'(8'h3C + 16 * p + i), "read back");
         end
         $display("test config %0d done", i);
      end
      sfr_w(8'hAA, 8'h0F, 8'h00);
      ale_width_sel = 2'h0;
      move(1'b1, 1'b1, 16'h0200, 8'h99, 8'h07);
      move(1'b0, 1'b1, 16'h0200, 8'h00, 8'h07);
      chk(rd_data, 8'h99, "short strobe read");
      sfr_w(8'hAB, 8'h0F, 8'h55);
      sfr_r(8'hAA, 8'h0F, 8'h00);
      for (int m = 4; m < 9; m++) begin
         mode_sel = 3'(m);
         move(1'b0, 1'b1, 16'h0200, 8'h00, 8'h3C);
      end
      $display("test refuse done");
      print_verdict();
   end
endmodule
